// ### rtcc_calendar.sv
// rtcc_calendar: bcd day, month, weekday and year counters
`timescale 1ns/1ps
`default_nettype none
module rtcc_calendar import rtcc_pkg::*; (
  input wire logic i_ref_clk, // system clock
  input wire logic i_resetn, // synchronous reset, active low
  input wire logic i_advance, // one-cycle pulse: next day
  input wire logic i_load, // one-cycle pulse: software write
  input wire rtcc_cal_t i_load_val, // value to load
  output rtcc_cal_t o_cal // current calendar
);
  rtcc_cal_t cal_q, cal_d;
  logic [7:0] day_v, mon_v, yr_v;

  always_comb begin
    cal_d = cal_q;
    day_v = {2'b00, cal_q.day_tens, cal_q.day_units};
    mon_v = {3'b000, cal_q.month_tens, cal_q.month_units};
    yr_v = {cal_q.year_tens, cal_q.year_units};
    if (i_load) begin
      cal_d = i_load_val; // see RL1
    end else if (i_advance) begin
      // modulo-7 weekday, 0 is sunday
      if (cal_q.weekday_count >= RTCC_WEEKDAY_LAST) begin
        cal_d.weekday_count = 3'h0; // see RL6
      end else begin
        cal_d.weekday_count = cal_q.weekday_count + 3'h1; // see RL6
      end
      // month end, leap february from year count
      if (day_v >= rtcc_last_day(mon_v, rtcc_is_leap(yr_v))) begin // see RL5
        day_v = RTCC_BCD_ONE; // see RL15
        // december and months above 12 fold back to january
        if (mon_v >= RTCC_MONTH_LAST) begin // see RL3
          mon_v = RTCC_BCD_ONE; // see RL2
          yr_v = rtcc_bcd_inc(yr_v); // see RL8
        end else begin
          mon_v = rtcc_bcd_inc(mon_v); // see RL2
        end
      end else begin
        day_v = rtcc_bcd_inc(day_v); // see RL4
      end
      cal_d.day_tens = day_v[5:4];
      cal_d.day_units = day_v[3:0];
      cal_d.month_tens = mon_v[4];
      cal_d.month_units = mon_v[3:0];
      cal_d.year_tens = yr_v[7:4]; // see RL7
      cal_d.year_units = yr_v[3:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) cal_q <= RTCC_RST_CAL;
    else cal_q <= cal_d;
  end

  assign o_cal = cal_q;
endmodule // rtcc_calendar
`default_nettype wire

// ### rtcc_events.sv
// rtcc_events: sticky event flags, enables and interrupt request
`timescale 1ns/1ps
`default_nettype none
module rtcc_events import rtcc_pkg::*; (
  input wire logic i_ref_clk, // system clock
  input wire logic i_resetn, // synchronous reset, active low
  input wire rtcc_evt_t i_set, // event pulses
  input wire logic [15:0] i_clr, // write-one-to-clear pulses
  input wire logic i_en_we, // enable register write strobe
  input wire logic [15:0] i_en_val, // new enable value
  output logic [15:0] o_flags, // sticky flags
  output logic [15:0] o_enables, // enable bits
  output logic o_irq // interrupt request, level
);
  rtcc_irq_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    // set wins over a clear in the same cycle
    st_d.flags = ((st_q.flags & ~i_clr) | i_set) & RTCC_EVT_MASK; // see RL10
    if (i_en_we) st_d.enables = i_en_val & RTCC_EVT_MASK; // see RL13
    st_d.irq = |(st_d.flags & st_d.enables); // see RL14
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_q <= '{flags: RTCC_RST_FLAGS, enables: RTCC_RST_ENABLES, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_flags = st_q.flags;
  assign o_enables = st_q.enables;
  assign o_irq = st_q.irq;
endmodule // rtcc_events
`default_nettype wire

// ### rtcc_pkg.sv
// rtcc_pkg: constants, types and helpers of the calendar and event block
package rtcc_pkg;
  // register byte offsets
  localparam logic [7:0] RTCC_OFS_MONTH_DAY = 8'h00;
  localparam logic [7:0] RTCC_OFS_YEAR_WEEK = 8'h04;
  localparam logic [7:0] RTCC_OFS_FLAGS = 8'h08;
  localparam logic [7:0] RTCC_OFS_ENABLES = 8'h0c;
  localparam logic [7:0] RTCC_OFS_STATUS = 8'h10;
  // field positions
  localparam int RTCC_POS_MONTH_TENS = 12;
  localparam int RTCC_POS_MONTH_UNITS = 8;
  localparam int RTCC_POS_DAY_TENS = 4;
  localparam int RTCC_POS_DAY_UNITS = 0;
  localparam int RTCC_POS_WEEKDAY = 8;
  localparam int RTCC_POS_YEAR_TENS = 4;
  localparam int RTCC_POS_YEAR_UNITS = 0;
  localparam int RTCC_POS_STAT_BUSY = 0;
  localparam int RTCC_POS_STAT_RUN = 1;
  // implemented flag and enable bits
  localparam logic [15:0] RTCC_EVT_MASK = 16'hf1ff;
  localparam logic [15:0] RTCC_RST_FLAGS = 16'h0000;
  localparam logic [15:0] RTCC_RST_ENABLES = 16'h0000;
  // calendar limits in bcd, then bus response codes
  localparam logic [7:0] RTCC_BCD_ONE = 8'h01;
  localparam logic [7:0] RTCC_MONTH_LAST = 8'h12;
  localparam logic [7:0] RTCC_YEAR_LAST = 8'h99;
  localparam logic [7:0] RTCC_DAYS_LONG = 8'h31;
  localparam logic [7:0] RTCC_DAYS_SHORT = 8'h30;
  localparam logic [7:0] RTCC_DAYS_FEB = 8'h28;
  localparam logic [7:0] RTCC_DAYS_FEB_LEAP = 8'h29;
  localparam logic [2:0] RTCC_WEEKDAY_LAST = 3'h6;
  localparam logic [1:0] RTCC_RESP_OKAY = 2'b00;
  localparam logic [1:0] RTCC_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic month_tens;
    logic [3:0] month_units;
    logic [1:0] day_tens;
    logic [3:0] day_units;
    logic [2:0] weekday_count;
    logic [3:0] year_tens;
    logic [3:0] year_units;
  } rtcc_cal_t;

  localparam rtcc_cal_t RTCC_RST_CAL = '{month_tens: 1'b0,
    month_units: 4'h1, day_tens: 2'h0, day_units: 4'h1,
    weekday_count: 3'h0, year_tens: 4'h0, year_units: 4'h0};

  // event pulses, laid out like the flag register
  typedef struct packed {
    logic regulation_done_flag;
    logic stopwatch_1hz_flag;
    logic stopwatch_10hz_flag;
    logic stopwatch_100hz_flag;
    logic [2:0] unused;
    logic alarm_match_flag;
    logic day_tick_flag;
    logic hour_tick_flag;
    logic minute_tick_flag;
    logic second_tick_flag;
    logic half_second_flag;
    logic quarter_second_flag;
    logic eighth_second_flag;
    logic thirtysecond_tick_flag;
  } rtcc_evt_t;

  typedef enum logic [1:0] {
    RTCC_WS_WAIT = 2'b00,
    RTCC_WS_DO = 2'b01,
    RTCC_WS_RESP = 2'b10
  } rtcc_wst_t;

  typedef enum logic {
    RTCC_RS_IDLE = 1'b0,
    RTCC_RS_RESP = 1'b1
  } rtcc_rst_t;

  typedef struct packed {
    rtcc_wst_t wst;
    logic aw_rdy;
    logic w_rdy;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    rtcc_rst_t rst;
    logic ar_rdy;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } rtcc_bus_st_t;

  localparam rtcc_bus_st_t RTCC_RST_BUS = '{wst: RTCC_WS_WAIT,
    aw_rdy: 1'b1, w_rdy: 1'b1, waddr: 8'h00, wdata: 16'h0000,
    wstrb: 2'b00, bvalid: 1'b0, bresp: 2'b00, rst: RTCC_RS_IDLE,
    ar_rdy: 1'b1, rvalid: 1'b0, rdata: 16'h0000, rresp: 2'b00};

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] enables;
    logic irq;
  } rtcc_irq_st_t;

  function automatic logic [7:0] rtcc_bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    if (v == RTCC_YEAR_LAST) r = 8'h00;
    else if (v[3:0] >= 4'h9) r = {v[7:4] + 4'h1, 4'h0};
    else r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // bcd year divisible by four
  function automatic logic rtcc_is_leap(input logic [7:0] y);
    logic r;
    if (y[4]) r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    return r;
  endfunction

  function automatic logic [7:0] rtcc_last_day(input logic [7:0] m,
                                               input logic leap);
    logic [7:0] r;
    case (m)
      8'h02: r = leap ? RTCC_DAYS_FEB_LEAP : RTCC_DAYS_FEB;
      8'h04, 8'h06, 8'h09, 8'h11: r = RTCC_DAYS_SHORT;
      default: r = RTCC_DAYS_LONG;
    endcase
    return r;
  endfunction
endpackage

// ### rtcc_top.sv
// rtcc_top: calendar counters and event interrupts behind axi4-lite
//
// Overview of operation
// RL1: month kept as bcd tens bit, units nibble
// RL2: month counts in bcd from 1 to 12
// RL3: software never loads month zero
// RL4: day kept as two-bit tens, four-bit units
// RL5: day limit depends on month and leap year
// RL6: weekday counts 0 to 6, sunday first
// RL7: year kept as bcd tens and units nibbles
// RL8: year counts in bcd from 0 to 99
// RL9: software avoids calendar writes while busy
// RL10: flags stick; writing one clears them
// RL11: bits 15 to 12: regulation, stopwatch ticks
// RL12: bits 8 to 0: alarm down to 1/32s
// RL13: enable bits mirror flag positions, one enables
// RL14: irq high while any enabled flag set
// RL15: year divisible by four is a leap year
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rtcc_top import rtcc_pkg::*; (
  input wire logic i_ref_clk, // 50 mhz system clock
  input wire logic i_resetn, // synchronous reset, active low
  // axi4-lite write address channel
  input wire logic [7:0] i_s_axi_awaddr, // write byte address
  input wire logic i_s_axi_awvalid, // write address valid
  output logic o_s_axi_awready, // write address ready
  // axi4-lite write data channel
  input wire logic [31:0] i_s_axi_wdata, // write data
  input wire logic [3:0] i_s_axi_wstrb, // write byte strobes
  input wire logic i_s_axi_wvalid, // write data valid
  output logic o_s_axi_wready, // write data ready
  // axi4-lite write response channel
  output logic [1:0] o_s_axi_bresp, // write response
  output logic o_s_axi_bvalid, // write response valid
  input wire logic i_s_axi_bready, // write response ready
  // axi4-lite read address channel
  input wire logic [7:0] i_s_axi_araddr, // read byte address
  input wire logic i_s_axi_arvalid, // read address valid
  output logic o_s_axi_arready, // read address ready
  // axi4-lite read data channel
  output logic [31:0] o_s_axi_rdata, // read data
  output logic [1:0] o_s_axi_rresp, // read response
  output logic o_s_axi_rvalid, // read data valid
  input wire logic i_s_axi_rready, // read data ready
  // clock core side
  input wire rtcc_evt_t i_events, // one-cycle event pulses
  input wire logic i_counter_busy, // counters being updated
  input wire logic i_clock_run, // clock counter running
  output logic o_irq // interrupt request, active high
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  function automatic logic [15:0] rtcc_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] strb);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic rtcc_mapped(input logic [7:0] a);
    logic r;
    case ({a[7:2], 2'b00})
      RTCC_OFS_MONTH_DAY, RTCC_OFS_YEAR_WEEK, RTCC_OFS_FLAGS,
      RTCC_OFS_ENABLES, RTCC_OFS_STATUS: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] rtcc_pack_md(input rtcc_cal_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[RTCC_POS_MONTH_TENS] = c.month_tens;
    w[RTCC_POS_MONTH_UNITS +: 4] = c.month_units;
    w[RTCC_POS_DAY_TENS +: 2] = c.day_tens;
    w[RTCC_POS_DAY_UNITS +: 4] = c.day_units;
    return w;
  endfunction

  function automatic logic [15:0] rtcc_pack_yw(input rtcc_cal_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[RTCC_POS_WEEKDAY +: 3] = c.weekday_count;
    w[RTCC_POS_YEAR_TENS +: 4] = c.year_tens;
    w[RTCC_POS_YEAR_UNITS +: 4] = c.year_units;
    return w;
  endfunction

  // ------------------------------------------------------------------
  // state and internal signals
  // ------------------------------------------------------------------

  rtcc_bus_st_t bus_q, bus_d;
  rtcc_cal_t cal;
  rtcc_cal_t cal_load_val;
  logic [15:0] flags;
  logic [15:0] enables;
  logic [15:0] md_word;
  logic [15:0] yw_word;
  logic [15:0] stat_word;
  logic [15:0] rd_word;
  logic [15:0] merged;
  logic [15:0] clr_bits;
  logic do_wr;
  logic wr_md;
  logic wr_yw;
  logic wr_fl;
  logic wr_en;
  logic cal_load;
  logic day_advance;

  assign md_word = rtcc_pack_md(cal);
  assign yw_word = rtcc_pack_yw(cal);

  // ------------------------------------------------------------------
  // write commit decode
  // ------------------------------------------------------------------

  // calendar writes are accepted even while busy
  assign do_wr = (bus_q.wst == RTCC_WS_DO); // see RL9
  assign wr_md = do_wr && ({bus_q.waddr[7:2], 2'b00} == RTCC_OFS_MONTH_DAY);
  assign wr_yw = do_wr && ({bus_q.waddr[7:2], 2'b00} == RTCC_OFS_YEAR_WEEK);
  assign wr_fl = do_wr && ({bus_q.waddr[7:2], 2'b00} == RTCC_OFS_FLAGS);
  assign wr_en = do_wr && ({bus_q.waddr[7:2], 2'b00} == RTCC_OFS_ENABLES);
  assign cal_load = wr_md || wr_yw;

  always_comb begin
    cal_load_val = cal;
    merged = 16'h0000;
    if (wr_md) begin
      merged = rtcc_merge(md_word, bus_q.wdata, bus_q.wstrb);
      cal_load_val.month_tens = merged[RTCC_POS_MONTH_TENS]; // see RL1
      cal_load_val.month_units = merged[RTCC_POS_MONTH_UNITS +: 4];
      cal_load_val.day_tens = merged[RTCC_POS_DAY_TENS +: 2]; // see RL4
      cal_load_val.day_units = merged[RTCC_POS_DAY_UNITS +: 4];
    end else if (wr_yw) begin
      merged = rtcc_merge(yw_word, bus_q.wdata, bus_q.wstrb);
      cal_load_val.weekday_count = merged[RTCC_POS_WEEKDAY +: 3];
      cal_load_val.year_tens = merged[RTCC_POS_YEAR_TENS +: 4]; // see RL7
      cal_load_val.year_units = merged[RTCC_POS_YEAR_UNITS +: 4];
    end
  end

  // write-one-to-clear on the flag register, per byte lane
  assign clr_bits = wr_fl ? rtcc_merge(16'h0000, bus_q.wdata, bus_q.wstrb)
                          : 16'h0000; // see RL10

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------

  always_comb begin
    stat_word = 16'h0000;
    stat_word[RTCC_POS_STAT_BUSY] = i_counter_busy;
    stat_word[RTCC_POS_STAT_RUN] = i_clock_run;
    case ({i_s_axi_araddr[7:2], 2'b00})
      RTCC_OFS_MONTH_DAY: rd_word = md_word;
      RTCC_OFS_YEAR_WEEK: rd_word = yw_word;
      RTCC_OFS_FLAGS: rd_word = flags; // see RL11
      RTCC_OFS_ENABLES: rd_word = enables; // see RL13
      RTCC_OFS_STATUS: rd_word = stat_word;
      default: rd_word = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------------

  always_comb begin
    bus_d = bus_q;
    // write side: address and data in either order
    case (bus_q.wst)
      RTCC_WS_WAIT: begin
        if (bus_q.aw_rdy && i_s_axi_awvalid) begin
          bus_d.waddr = i_s_axi_awaddr;
          bus_d.aw_rdy = 1'b0;
        end
        if (bus_q.w_rdy && i_s_axi_wvalid) begin
          bus_d.wdata = i_s_axi_wdata[15:0];
          bus_d.wstrb = i_s_axi_wstrb[1:0];
          bus_d.w_rdy = 1'b0;
        end
        if (!bus_d.aw_rdy && !bus_d.w_rdy) begin
          bus_d.wst = RTCC_WS_DO;
        end
      end
      RTCC_WS_DO: begin
        bus_d.bvalid = 1'b1;
        bus_d.bresp = rtcc_mapped(bus_q.waddr) ? RTCC_RESP_OKAY
                                               : RTCC_RESP_SLVERR;
        bus_d.wst = RTCC_WS_RESP;
      end
      RTCC_WS_RESP: begin
        if (i_s_axi_bready) begin
          bus_d.bvalid = 1'b0;
          bus_d.aw_rdy = 1'b1;
          bus_d.w_rdy = 1'b1;
          bus_d.wst = RTCC_WS_WAIT;
        end
      end
      default: begin
        bus_d.wst = RTCC_WS_WAIT;
        bus_d.aw_rdy = 1'b1;
        bus_d.w_rdy = 1'b1;
        bus_d.bvalid = 1'b0;
      end
    endcase
    // read side: data captured when the address is taken
    case (bus_q.rst)
      RTCC_RS_IDLE: begin
        if (i_s_axi_arvalid) begin
          bus_d.rdata = rd_word;
          bus_d.rresp = rtcc_mapped(i_s_axi_araddr) ? RTCC_RESP_OKAY
                                                    : RTCC_RESP_SLVERR;
          bus_d.rvalid = 1'b1;
          bus_d.ar_rdy = 1'b0;
          bus_d.rst = RTCC_RS_RESP;
        end
      end
      RTCC_RS_RESP: begin
        if (i_s_axi_rready) begin
          bus_d.rvalid = 1'b0;
          bus_d.ar_rdy = 1'b1;
          bus_d.rst = RTCC_RS_IDLE;
        end
      end
      default: begin
        bus_d.rst = RTCC_RS_IDLE;
        bus_d.ar_rdy = 1'b1;
        bus_d.rvalid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) bus_q <= RTCC_RST_BUS;
    else bus_q <= bus_d;
  end

  assign o_s_axi_awready = bus_q.aw_rdy;
  assign o_s_axi_wready = bus_q.w_rdy;
  assign o_s_axi_bvalid = bus_q.bvalid;
  assign o_s_axi_bresp = bus_q.bresp;
  assign o_s_axi_arready = bus_q.ar_rdy;
  assign o_s_axi_rvalid = bus_q.rvalid;
  assign o_s_axi_rresp = bus_q.rresp;
  assign o_s_axi_rdata = {16'h0000, bus_q.rdata};

  // ------------------------------------------------------------------
  // calendar counters
  // ------------------------------------------------------------------

  // day rollover from the hour counter advances the date while running
  assign day_advance = i_events.day_tick_flag && i_clock_run; // see RL5

  rtcc_calendar u_calendar (
    .i_ref_clk (i_ref_clk),
    .i_resetn (i_resetn),
    .i_advance (day_advance),
    .i_load (cal_load),
    .i_load_val (cal_load_val),
    .o_cal (cal)
  );

  // ------------------------------------------------------------------
  // event flags and interrupt
  // ------------------------------------------------------------------

  // event struct layout places each source at its flag bit
  rtcc_events u_events (
    .i_ref_clk (i_ref_clk),
    .i_resetn (i_resetn),
    .i_set (i_events), // see RL12
    .i_clr (clr_bits),
    .i_en_we (wr_en),
    .i_en_val (rtcc_merge(enables, bus_q.wdata, bus_q.wstrb)),
    .o_flags (flags),
    .o_enables (enables),
    .o_irq (o_irq)
  );

endmodule // rtcc_top
`default_nettype wire

// ### rtcc_top_sva.sv
// rtcc_top_sva: bus timing and interrupt checks for rtcc_top
`timescale 1ns/1ps
`default_nettype none
module rtcc_top_sva import rtcc_pkg::*; (
  input wire logic i_ref_clk, // clock
  input wire logic i_resetn, // reset, active low
  input wire logic i_s_axi_awvalid, // aw valid
  input wire logic o_s_axi_awready, // aw ready
  input wire logic i_s_axi_wvalid, // w valid
  input wire logic o_s_axi_wready, // w ready
  input wire logic [1:0] o_s_axi_bresp, // b resp
  input wire logic o_s_axi_bvalid, // b valid
  input wire logic i_s_axi_bready, // b ready
  input wire logic i_s_axi_arvalid, // ar valid
  input wire logic o_s_axi_arready, // ar ready
  input wire logic [31:0] o_s_axi_rdata, // r data
  input wire logic [1:0] o_s_axi_rresp, // r resp
  input wire logic o_s_axi_rvalid, // r valid
  input wire logic i_s_axi_rready, // r ready
  input wire rtcc_evt_t i_events, // event pulses
  input wire logic o_irq // interrupt
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_rst_idle;
    disable iff (1'b0)
    !i_resetn |=> !o_s_axi_bvalid && !o_s_axi_rvalid && !o_irq;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs active during reset");
  property p_irq_src;
    $rose(o_irq) |-> (16'($past(i_events)) & RTCC_EVT_MASK) != 16'h0000
      || !$past(o_s_axi_awready) || !$past(o_s_axi_awready, 2);
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("irq rose without event or write");
  property p_irq_hold;
    o_irq && o_s_axi_awready && !o_s_axi_bvalid && !$past(o_s_axi_bvalid)
      |=> o_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without a write");
  property p_wr_lat;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
      |=> !o_s_axi_awready && !o_s_axi_bvalid ##1 o_s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response timing wrong");
  property p_b_drop;
    o_s_axi_bvalid && i_s_axi_bready
      |=> !o_s_axi_bvalid && o_s_axi_awready && o_s_axi_wready;
  endproperty
  a_b_drop: assert property (p_b_drop)
    else $error("write channel not freed");
  property p_rd_lat;
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  property p_r_drop;
    o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid && o_s_axi_arready;
  endproperty
  a_r_drop: assert property (p_r_drop)
    else $error("read channel not freed");
  property p_rdata_hi;
    o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("upper read data not zero");
  property p_err_zero;
    o_s_axi_rvalid && o_s_axi_rresp != RTCC_RESP_OKAY
      |-> o_s_axi_rresp == RTCC_RESP_SLVERR && o_s_axi_rdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error read carries data");
endmodule // rtcc_top_sva
bind rtcc_top rtcc_top_sva u_sva (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_s_axi_rready(i_s_axi_rready), .i_events(i_events), .o_irq(o_irq)
);
`default_nettype wire

// ### tb_rtc_calendar_and_interrupts.sv
// tb_rtc_calendar_and_interrupts: self-checking bench for rtcc_top
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_calendar_and_interrupts import rtcc_pkg::*; ;
  logic clk, rstn, awv, wv, bry, arv, rry, busy, run;
  logic awr, wrd, bv, arr, rv, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdd;
  logic [3:0] ws;
  logic [1:0] br, rr;
  rtcc_evt_t ev;
  int n_errors = 0;
  int tests_run = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic iq[$];
  logic chk = 1'b0;
  logic [31:0] seed = 32'h0000_93f8;
  localparam logic [1:0] OK = RTCC_RESP_OKAY;
  localparam logic [1:0] ER = RTCC_RESP_SLVERR;
  localparam logic [15:0] CMD [8] = '{16'h0228, 16'h0229, 16'h0228,
    16'h0430, 16'h0930, 16'h1130, 16'h1231, 16'h0109};
  localparam logic [15:0] CYW [8] = '{16'h0004, 16'h0104, 16'h0103,
    16'h0610, 16'h0219, 16'h0598, 16'h0599, 16'h0312};
  localparam logic [15:0] EMD [8] = '{16'h0229, 16'h0301, 16'h0301,
    16'h0501, 16'h1001, 16'h1201, 16'h0101, 16'h0110};
  localparam logic [15:0] EYW [8] = '{16'h0104, 16'h0204, 16'h0203,
    16'h0010, 16'h0319, 16'h0698, 16'h0600, 16'h0412};
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic conclude();
    // let the monitor take the last answer, then count unseen ones
    @(posedge clk);
    if (rq.size() + bq.size() + iq.size() != 0) n_errors++;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_b(input logic [1:0] e, input logic [1:0] g);
    cmp_rd({32'h0000_0000, e}, {32'h0000_0000, g});
  endtask
  task automatic cmp_irq(input logic e, input logic g);
    cmp_rd({33'h0_0000_0000, e}, {33'h0_0000_0000, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] e);
    int n;
    bq.push_back(e);
    @(posedge clk);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    if (n == 100) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] e);
    int n;
    rq.push_back({e, 16'h0000, d});
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
    if (n == 100) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic pulse(input logic [15:0] e);
    @(posedge clk);
    ev <= rtcc_evt_t'(e);
    @(posedge clk);
    ev <= rtcc_evt_t'(16'h0000);
  endtask
  task automatic chk_irq(input logic e);
    iq.push_back(e);
    @(posedge clk);
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rv && rry) cmp_rd(rq.pop_front(), {rr, rdd});
    if (bv && bry) cmp_b(bq.pop_front(), br);
    if (chk) cmp_irq(iq.pop_front(), irq);
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  rtcc_top uut (
    .i_ref_clk(clk), .i_resetn(rstn),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrd), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdd), .o_s_axi_rresp(rr),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .i_events(ev),
    .i_counter_busy(busy), .i_clock_run(run), .o_irq(irq)
  );
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] m;
    {rstn, awv, wv, bry, arv, rry, busy, run} = 8'h00;
    {awa, ara, wd} = 48'h0000_0000_0000;
    ws = 4'h3;
    ev = rtcc_evt_t'(16'h0000);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(RTCC_OFS_MONTH_DAY, 16'h0101, OK);
    rd(RTCC_OFS_YEAR_WEEK, 16'h0000, OK);
    rd(RTCC_OFS_FLAGS, 16'h0000, OK);
    rd(RTCC_OFS_ENABLES, 16'h0000, OK);
    rd(8'h20, 16'h0000, ER);
    wr(8'h20, 16'hffff, ER);
    wr(RTCC_OFS_ENABLES, 16'hffff, OK);
    rd(RTCC_OFS_ENABLES, RTCC_EVT_MASK, OK);
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      wr(RTCC_OFS_ENABLES, m, OK);
      pulse(m);
      chk_irq(RTCC_EVT_MASK[i]);
      rd(RTCC_OFS_FLAGS, m & RTCC_EVT_MASK, OK);
      wr(RTCC_OFS_FLAGS, m, OK);
      chk_irq(1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      m = 16'(xs());
      wr(RTCC_OFS_ENABLES, 16'h0000, OK);
      pulse(m);
      chk_irq(1'b0);
      wr(RTCC_OFS_FLAGS, 16'h0000, OK);
      rd(RTCC_OFS_FLAGS, m & RTCC_EVT_MASK, OK);
      wr(RTCC_OFS_ENABLES, m, OK);
      chk_irq(|(m & RTCC_EVT_MASK));
      wr(RTCC_OFS_FLAGS, m & 16'h00ff, OK);
      rd(RTCC_OFS_FLAGS, m & 16'hf100, OK);
      wr(RTCC_OFS_FLAGS, 16'hffff, OK);
    end
    wr(RTCC_OFS_ENABLES, 16'h0000, OK);
    run <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(RTCC_OFS_MONTH_DAY, CMD[k], OK);
      wr(RTCC_OFS_YEAR_WEEK, CYW[k], OK);
      pulse(16'h0080);
      rd(RTCC_OFS_MONTH_DAY, EMD[k], OK);
      rd(RTCC_OFS_YEAR_WEEK, EYW[k], OK);
    end
    run <= 1'b0;
    busy <= 1'b1;
    pulse(16'h0080);
    rd(RTCC_OFS_MONTH_DAY, EMD[7], OK);
    rd(RTCC_OFS_STATUS, 16'h0001, OK);
    wr(RTCC_OFS_STATUS, 16'hffff, OK);
    busy <= 1'b0;
    // byte strobes: unstrobed lanes keep value, flags not cleared
    ws <= 4'h1;
    wr(RTCC_OFS_YEAR_WEEK, 16'h0755, OK);
    rd(RTCC_OFS_YEAR_WEEK, 16'h0455, OK);
    ws <= 4'h2;
    wr(RTCC_OFS_FLAGS, 16'hffff, OK);
    rd(RTCC_OFS_FLAGS, 16'h0080, OK);
    conclude();
  end
endmodule // tb_rtc_calendar_and_interrupts
`default_nettype wire
